//--- dsd_cfg.svh
`ifndef DSD_CFG_SVH
`define DSD_CFG_SVH

`define DSD_PC_W 12
`define DSD_STACK_DEPTH 6
`define DSD_PM_SIZE 4096
`define DSD_BASE_W 6
`define DSD_WIN_OFS_W 6

`define DSD_BANK_LO 8'h00
`define DSD_BANK_HI 8'h3F
`define DSD_WIN_LO 8'h40
`define DSD_WIN_HI 8'h7F
`define DSD_CORE_LO 8'h80
`define DSD_CORE_HI 8'h83
`define DSD_RAM_LO 8'h84
`define DSD_RAM_HI 8'hBF
`define DSD_PDATA_LO 8'hC0
`define DSD_PDATA_HI 8'hC2
`define DSD_PDIR_LO 8'hC4
`define DSD_PDIR_HI 8'hC6
`define DSD_INT_OPT 8'hC8
`define DSD_WIN_BASE 8'hC9
`define DSD_POPT_LO 8'hCC
`define DSD_POPT_HI 8'hCE
`define DSD_TMR_LO 8'hD0
`define DSD_TMR_HI 8'hDB
`define DSD_OSC_CTL 8'hDC
`define DSD_MISC 8'hDD
`define DSD_SPI_LO 8'hE0
`define DSD_SPI_HI 8'hE2
`define DSD_BANK_SEL 8'hE8
`define DSD_NVM_CTL 8'hEA
`define DSD_ACC 8'hFF

`define DSD_SEL_RAM2 4
`define DSD_SEL_NVM1 1
`define DSD_SEL_NVM0 0

`define DSD_NVM_CTL_RST 8'h00
`define DSD_RD_FILL 8'hFF

`endif

//--- dsd_pkg.sv
`include "dsd_cfg.svh"

package dsd_pkg;

    typedef enum logic [3:0] {
        RG_BANK = 4'h0,
        RG_WINDOW = 4'h1,
        RG_CORE = 4'h2,
        RG_RAM = 4'h3,
        RG_PERIPH = 4'h4,
        RG_WO_PERIPH = 4'h5,
        RG_BASE = 4'h6,
        RG_BANKSEL = 4'h7,
        RG_NVMCTL = 4'h8,
        RG_RSVD = 4'h9
    } dsd_region_t;

    function automatic dsd_region_t dsd_decode(input logic [7:0] a);
        dsd_region_t r;
        r = RG_RSVD;
        if (a <= `DSD_BANK_HI)
            r = RG_BANK;
        else if (a <= `DSD_WIN_HI)
            r = RG_WINDOW;
        else if (a <= `DSD_CORE_HI || a == `DSD_ACC)
            r = RG_CORE;
        else if (a <= `DSD_RAM_HI)
            r = RG_RAM;
        else if ((a >= `DSD_PDATA_LO && a <= `DSD_PDATA_HI) ||
                 (a >= `DSD_PDIR_LO && a <= `DSD_PDIR_HI) ||
                 (a >= `DSD_POPT_LO && a <= `DSD_POPT_HI) ||
                 (a >= `DSD_TMR_LO && a <= `DSD_TMR_HI) ||
                 a == `DSD_MISC ||
                 (a >= `DSD_SPI_LO && a <= `DSD_SPI_HI))
            r = RG_PERIPH;
        else if (a == `DSD_INT_OPT || a == `DSD_OSC_CTL)
            r = RG_WO_PERIPH;
        else if (a == `DSD_WIN_BASE)
            r = RG_BASE;
        else if (a == `DSD_BANK_SEL)
            r = RG_BANKSEL;
        else if (a == `DSD_NVM_CTL)
            r = RG_NVMCTL;
        return r;
    endfunction : dsd_decode

endpackage : dsd_pkg

//--- dsd_ret_stack.sv
`timescale 1ns/10ps
`default_nettype none
`include "dsd_cfg.svh"

module dsd_ret_stack #(
    parameter int DEPTH = `DSD_STACK_DEPTH,
    parameter int WIDTH = `DSD_PC_W
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic push,
    input wire logic pop,
    input wire logic [WIDTH-1:0] push_addr,
    output logic [WIDTH-1:0] top_ff
);
    import dsd_pkg::*;

    logic [WIDTH-1:0] lvl_ff [DEPTH];

    // Shift register stack: overflow drops the oldest level silently
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < DEPTH; i++)
                lvl_ff[i] <= '0;
        end
        else if (push)
        begin
            lvl_ff[0] <= push_addr;
            for (int i = 1; i < DEPTH; i++)
                lvl_ff[i] <= lvl_ff[i-1];
        end
        else if (pop)
        begin
            for (int i = 0; i < DEPTH - 1; i++)
                lvl_ff[i] <= lvl_ff[i+1];
        end
    end

    assign top_ff = lvl_ff[0];

    push_top_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        push |=> top_ff == $past(push_addr))
        else $error("stack top does not hold pushed address");

    pop_order_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        push ##1 (push && !pop) ##1 (pop && !push) |=>
        top_ff == $past(push_addr, 3))
        else $error("stack pop does not return older entry");

    push_cov_c: cover property (@(posedge ref_clk) disable iff (sys_rst)
        push ##1 pop);

endmodule : dsd_ret_stack

`default_nettype wire

//--- dsd_wo_regs.sv
`timescale 1ns/10ps
`default_nettype none
`include "dsd_cfg.svh"

module dsd_wo_regs (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic base_we,
    input wire logic bank_we,
    input wire logic nvm_we,
    input wire logic [7:0] wdata,
    output logic [`DSD_BASE_W-1:0] window_base_ff,
    output logic [7:0] bank_select_ff,
    output logic [7:0] nvm_control_ff
);
    import dsd_pkg::*;

    // No reset on purpose: contents are undefined until software writes
    always_ff @(posedge ref_clk)
    begin
        if (base_we)
            window_base_ff <= wdata[`DSD_BASE_W-1:0];
    end

    always_ff @(posedge ref_clk)
    begin
        if (bank_we)
            bank_select_ff <= wdata;
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            nvm_control_ff <= `DSD_NVM_CTL_RST;
        else if (nvm_we)
            nvm_control_ff <= wdata;
    end

    base_low_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
        base_we |=> window_base_ff == $past(wdata[5:0]))
        else $error("window base does not take low six bits");

    // Case equality, so a never-written selector counts as unchanged
    bank_hold_a: assert property (@(posedge ref_clk)
        sys_rst && !bank_we |=> bank_select_ff === $past(bank_select_ff))
        else $error("bank select changed by reset");

    base_hold_a: assert property (@(posedge ref_clk)
        sys_rst && !base_we |=> window_base_ff === $past(window_base_ff))
        else $error("window base changed by reset");

endmodule : dsd_wo_regs

`default_nettype wire

//--- dsd_decoder.sv
`timescale 1ns/10ps
`default_nettype none
`include "dsd_cfg.svh"

module dsd_decoder #(
    parameter int PC_W = `DSD_PC_W,
    parameter int STACK_DEPTH = `DSD_STACK_DEPTH,
    parameter int PM_SIZE = `DSD_PM_SIZE
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [7:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    input wire logic cpu_wr,
    input wire logic cpu_rd,
    input wire logic [PC_W-1:0] program_counter,
    input wire logic stack_push,
    input wire logic stack_pop,
    input wire logic readout_protect,
    input wire logic ext_rd_req,
    input wire logic [PC_W-1:0] ext_addr,
    input wire logic [7:0] pm_rdata,
    input wire logic [7:0] ram_rdata,
    input wire logic [7:0] page_rdata,
    input wire logic [7:0] periph_rdata,
    input wire logic [7:0] core_rdata,
    output logic [7:0] cpu_rdata_ff,
    output logic cpu_rvalid_ff,
    output logic [PC_W-1:0] pm_addr_ff,
    output logic pm_re_ff,
    output logic [7:0] acc_addr_ff,
    output logic [7:0] acc_wdata_ff,
    output logic ram_we_ff,
    output logic ram_re_ff,
    output logic page_we_ff,
    output logic page_re_ff,
    output logic [2:0] page_sel_ff,
    output logic periph_we_ff,
    output logic periph_re_ff,
    output logic core_we_ff,
    output logic core_re_ff,
    output logic [7:0] nvm_control_ff,
    output logic [PC_W-1:0] ret_addr_ff,
    output logic [7:0] ext_rdata_ff,
    output logic ext_ack_ff,
    output logic ext_denied_ff
);
    import dsd_pkg::*;

    dsd_region_t region;
    dsd_region_t region_ff;
    logic wr_go;
    logic rd_go;
    logic [`DSD_BASE_W-1:0] window_base;
    logic [7:0] bank_select;
    logic [2:0] pages;
    logic [PC_W-1:0] win_addr;
    logic in_range;
    logic win_rd;
    logic ext_take;
    logic ext_ok;
    logic rd_pend_ff;
    logic win_oor_ff;
    logic page_miss_ff;
    logic ext_pend_ff;
    logic [7:0] nxt_rdata;

    // A write wins when both strobes arrive together
    assign wr_go = cpu_wr;
    assign rd_go = cpu_rd & ~cpu_wr;
    assign region = dsd_decode(cpu_addr);

    dsd_wo_regs u_wo_regs (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .base_we(wr_go && region == RG_BASE),
        .bank_we(wr_go && region == RG_BANKSEL),
        .nvm_we(wr_go && region == RG_NVMCTL),
        .wdata(cpu_wdata),
        .window_base_ff(window_base),
        .bank_select_ff(bank_select),
        .nvm_control_ff(nvm_control_ff)
    );

    dsd_ret_stack #(
        .DEPTH(STACK_DEPTH),
        .WIDTH(PC_W)
    ) u_stack (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .push(stack_push),
        .pop(stack_pop),
        .push_addr(program_counter),
        .top_ff(ret_addr_ff)
    );

    assign pages = {bank_select[`DSD_SEL_RAM2], bank_select[`DSD_SEL_NVM1],
                    bank_select[`DSD_SEL_NVM0]};

    // Base supplies the upper bits, the access the lower six
    assign win_addr = PC_W'({window_base, cpu_addr[`DSD_WIN_OFS_W-1:0]});
    // Past the implemented memory no fetch is made at all
    assign in_range = 32'(win_addr) < PM_SIZE;
    assign win_rd = rd_go && region == RG_WINDOW;
    // The core window read owns the program port; external reads retry
    assign ext_take = ext_rd_req && !win_rd;
    assign ext_ok = ext_take && !readout_protect;

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            pm_re_ff <= 1'b0;
            pm_addr_ff <= '0;
        end
        else
        begin
            pm_re_ff <= (win_rd && in_range) || ext_ok;
            if (win_rd)
                pm_addr_ff <= win_addr;
            else if (ext_ok)
                pm_addr_ff <= ext_addr;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            ram_we_ff <= 1'b0;
            ram_re_ff <= 1'b0;
            core_we_ff <= 1'b0;
            core_re_ff <= 1'b0;
        end
        else
        begin
            ram_we_ff <= wr_go && region == RG_RAM;
            ram_re_ff <= rd_go && region == RG_RAM;
            core_we_ff <= wr_go && region == RG_CORE;
            core_re_ff <= rd_go && region == RG_CORE;
        end
    end

    // With no page selected the access is dropped; several are not filtered
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            page_we_ff <= 1'b0;
            page_re_ff <= 1'b0;
            page_sel_ff <= '0;
        end
        else
        begin
            page_we_ff <= wr_go && region == RG_BANK && pages != 3'h0;
            page_re_ff <= rd_go && region == RG_BANK && pages != 3'h0;
            page_sel_ff <= (region == RG_BANK) ? pages : 3'h0;
        end
    end

    // Write-only peripheral registers get writes but never a read strobe
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            periph_we_ff <= 1'b0;
            periph_re_ff <= 1'b0;
        end
        else
        begin
            periph_we_ff <= wr_go && (region == RG_PERIPH ||
                                      region == RG_WO_PERIPH);
            periph_re_ff <= rd_go && region == RG_PERIPH;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            acc_addr_ff <= '0;
            acc_wdata_ff <= '0;
        end
        else
        begin
            if (wr_go || rd_go)
                acc_addr_ff <= cpu_addr;
            if (wr_go)
                acc_wdata_ff <= cpu_wdata;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            rd_pend_ff <= 1'b0;
            region_ff <= RG_RSVD;
            win_oor_ff <= 1'b0;
            page_miss_ff <= 1'b0;
        end
        else
        begin
            rd_pend_ff <= rd_go;
            region_ff <= region;
            win_oor_ff <= !in_range;
            page_miss_ff <= pages == 3'h0;
        end
    end

    always_comb
    begin
        nxt_rdata = `DSD_RD_FILL;
        case (region_ff)
            RG_WINDOW: nxt_rdata = win_oor_ff ? `DSD_RD_FILL : pm_rdata;
            RG_RAM: nxt_rdata = ram_rdata;
            RG_CORE: nxt_rdata = core_rdata;
            RG_PERIPH: nxt_rdata = periph_rdata;
            RG_BANK: nxt_rdata = page_miss_ff ? `DSD_RD_FILL : page_rdata;
            RG_NVMCTL: nxt_rdata = nvm_control_ff;
            default: nxt_rdata = `DSD_RD_FILL;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            cpu_rdata_ff <= '0;
            cpu_rvalid_ff <= 1'b0;
        end
        else
        begin
            cpu_rvalid_ff <= rd_pend_ff;
            if (rd_pend_ff)
                cpu_rdata_ff <= nxt_rdata;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            ext_pend_ff <= 1'b0;
            ext_ack_ff <= 1'b0;
            ext_denied_ff <= 1'b0;
            ext_rdata_ff <= '0;
        end
        else
        begin
            ext_pend_ff <= ext_ok;
            ext_ack_ff <= ext_pend_ff;
            ext_denied_ff <= ext_take && readout_protect;
            if (ext_pend_ff)
                ext_rdata_ff <= pm_rdata;
        end
    end

    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    win_addr_a: assert property (win_rd && in_range |=> pm_re_ff &&
        pm_addr_ff == {$past(window_base), $past(cpu_addr[5:0])})
        else $error("window address not base over low bits");

    win_data_a: assert property (win_rd && in_range |->
        ##2 cpu_rvalid_ff && cpu_rdata_ff == $past(pm_rdata))
        else $error("window read not returned from program memory");

    ram_map_a: assert property (
        rd_go && cpu_addr inside {[8'h84:8'hBF]} |=> ram_re_ff && !page_re_ff)
        else $error("general RAM read not decoded");

    bank_map_a: assert property (
        wr_go && cpu_addr <= 8'h3F && pages != 3'h0 |=>
        page_we_ff && page_sel_ff == $past(pages))
        else $error("banked write not routed to selected page");

    core_map_a: assert property (
        rd_go && cpu_addr inside {[8'h80:8'h83], 8'hFF} |=> core_re_ff)
        else $error("core register read not decoded");

    port_map_a: assert property (
        wr_go && cpu_addr inside {[8'hC0:8'hC2], [8'hC4:8'hC6],
        [8'hCC:8'hCE]} |=> periph_we_ff)
        else $error("port register write not decoded");

    timer_map_a: assert property (
        rd_go && cpu_addr inside {[8'hD0:8'hDB]} |=> periph_re_ff)
        else $error("timer or converter read not decoded");

    wo_read_a: assert property (
        rd_go && cpu_addr inside {8'hC8, 8'hC9, 8'hDC} |=>
        !periph_re_ff ##1 cpu_rdata_ff == 8'hFF)
        else $error("write-only register read not filled");

    rsvd_quiet_a: assert property (
        (wr_go || rd_go) && region == RG_RSVD |=> !(ram_we_ff || ram_re_ff ||
        page_we_ff || periph_we_ff || periph_re_ff || core_we_ff) ##1
        (!cpu_rvalid_ff || cpu_rdata_ff == 8'hFF))
        else $error("reserved access had a side effect");

    protect_a: assert property (
        ext_take && readout_protect |=> !pm_re_ff && ext_denied_ff ##1
        !ext_ack_ff)
        else $error("protected program memory was read");

    nvm_rst_a: assert property ($fell(sys_rst) |->
        nvm_control_ff == 8'h00)
        else $error("storage control not cleared by reset");

    win_cov_c: cover property (win_rd && in_range ##2 cpu_rvalid_ff);
    ext_cov_c: cover property (ext_ok ##2 ext_ack_ff);
    page_cov_c: cover property (wr_go && region == RG_BANK ##1 page_we_ff);

endmodule : dsd_decoder

`default_nettype wire

//--- dsd_core_model.sv
`timescale 1ns/10ps
`default_nettype none

module dsd_core_model (
    input wire logic ref_clk,
    input wire logic [7:0] acc_addr_ff,
    input wire logic [11:0] pm_addr_ff,
    output logic [7:0] cpu_addr,
    output logic [7:0] cpu_wdata,
    output logic cpu_wr,
    output logic cpu_rd,
    output logic [7:0] pm_rdata,
    output logic [7:0] ram_rdata,
    output logic [7:0] page_rdata,
    output logic [7:0] periph_rdata,
    output logic [7:0] core_rdata
);
    logic [7:0] base_image;

    // Data follows the address, so a wrong address shows up as wrong data
    assign pm_rdata = pm_addr_ff[7:0] ^ {pm_addr_ff[11:8], 4'h5};
    assign ram_rdata = acc_addr_ff ^ 8'h11;
    assign page_rdata = acc_addr_ff ^ 8'h22;
    assign periph_rdata = acc_addr_ff ^ 8'h33;
    assign core_rdata = acc_addr_ff ^ 8'h44;

    initial
    begin
        cpu_addr = 8'h00;
        cpu_wdata = 8'h00;
        cpu_wr = 1'b0;
        cpu_rd = 1'b0;
        base_image = 8'h00;
    end

    // Released lines show inverted values so stale data cannot pass
    task automatic access(input logic wr, input logic [7:0] a,
                          input logic [7:0] d);
        @(negedge ref_clk);
        cpu_addr = a;
        cpu_wdata = d;
        cpu_wr = wr;
        cpu_rd = !wr;
        @(negedge ref_clk);
        cpu_wr = 1'b0;
        cpu_rd = 1'b0;
        cpu_addr = ~a;
        cpu_wdata = ~d;
    endtask : access

    // Image first, so an interrupt between the two never loses the base
    task automatic set_base(input logic [7:0] v);
        base_image = v;
        access(1'b1, 8'hC9, v);
    endtask : set_base
endmodule : dsd_core_model
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    import dsd_pkg::*;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] cpu_addr, cpu_wdata, pm_rdata, ram_rdata, page_rdata;
    logic [7:0] periph_rdata, core_rdata, cpu_rdata_ff, acc_addr_ff;
    logic [7:0] acc_wdata_ff, nvm_control_ff, ext_rdata_ff;
    logic cpu_wr, cpu_rd, cpu_rvalid_ff, pm_re_ff, ram_we_ff, ram_re_ff;
    logic page_we_ff, page_re_ff, periph_we_ff, periph_re_ff;
    logic core_we_ff, core_re_ff, ext_ack_ff, ext_denied_ff;
    logic stack_push = 1'b0;
    logic stack_pop = 1'b0;
    logic readout_protect = 1'b0;
    logic ext_rd_req = 1'b0;
    logic [11:0] program_counter = 12'h000;
    logic [11:0] ext_addr = 12'h000;
    logic [11:0] pm_addr_ff, ret_addr_ff, seen_pm;
    logic [2:0] page_sel_ff, seen_sel;
    int fails = 0;
    int check_count = 0;

    always #20 ref_clk = ~ref_clk;

    dsd_core_model core (.ref_clk(ref_clk), .acc_addr_ff(acc_addr_ff),
        .pm_addr_ff(pm_addr_ff), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
        .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .pm_rdata(pm_rdata),
        .ram_rdata(ram_rdata), .page_rdata(page_rdata),
        .periph_rdata(periph_rdata), .core_rdata(core_rdata));

    dsd_decoder DUT (.ref_clk(ref_clk), .sys_rst(sys_rst),
        .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr),
        .cpu_rd(cpu_rd), .program_counter(program_counter),
        .stack_push(stack_push), .stack_pop(stack_pop),
        .readout_protect(readout_protect), .ext_rd_req(ext_rd_req),
        .ext_addr(ext_addr), .pm_rdata(pm_rdata), .ram_rdata(ram_rdata),
        .page_rdata(page_rdata), .periph_rdata(periph_rdata),
        .core_rdata(core_rdata), .cpu_rdata_ff(cpu_rdata_ff),
        .cpu_rvalid_ff(cpu_rvalid_ff), .pm_addr_ff(pm_addr_ff),
        .pm_re_ff(pm_re_ff), .acc_addr_ff(acc_addr_ff),
        .acc_wdata_ff(acc_wdata_ff), .ram_we_ff(ram_we_ff),
        .ram_re_ff(ram_re_ff), .page_we_ff(page_we_ff),
        .page_re_ff(page_re_ff), .page_sel_ff(page_sel_ff),
        .periph_we_ff(periph_we_ff), .periph_re_ff(periph_re_ff),
        .core_we_ff(core_we_ff), .core_re_ff(core_re_ff),
        .nvm_control_ff(nvm_control_ff), .ret_addr_ff(ret_addr_ff),
        .ext_rdata_ff(ext_rdata_ff), .ext_ack_ff(ext_ack_ff),
        .ext_denied_ff(ext_denied_ff));

    function automatic logic [7:0] pmv(input logic [11:0] a);
        return a[7:0] ^ {a[11:8], 4'h5};
    endfunction : pmv

    task automatic stop_test;
        if (fails == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : stop_test

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        check_count++;
        if (exp !== got)
        begin
            fails++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    // Strobes: core, ram, periph, page, program read
    task automatic rd_chk(input logic [7:0] a, input logic [4:0] stb,
                          input logic [7:0] d);
        core.access(1'b0, a, 8'h00);
        chk("read strobes", stb,
            {core_re_ff, ram_re_ff, periph_re_ff, page_re_ff, pm_re_ff});
        seen_pm = pm_addr_ff;
        seen_sel = page_sel_ff;
        @(negedge ref_clk);
        chk("rvalid", 1'b1, cpu_rvalid_ff);
        chk("rdata", d, cpu_rdata_ff);
    endtask : rd_chk

    // Strobes: core, ram, periph, page
    task automatic wr_chk(input logic [7:0] a, input logic [7:0] d,
                          input logic [3:0] stb);
        core.access(1'b1, a, d);
        chk("write strobes", stb,
            {core_we_ff, ram_we_ff, periph_we_ff, page_we_ff});
    endtask : wr_chk

    task automatic t_window;
        core.set_base(8'h02);
        rd_chk(8'h45, 5'h01, pmv(12'h085));
        chk("window addr", 12'h085, seen_pm);
        core.set_base(8'hFF);
        rd_chk(8'h7F, 5'h01, pmv(12'hFFF));
        chk("window top", 12'hFFF, seen_pm);
        core.set_base(8'h40);
        rd_chk(8'h40, 5'h01, pmv(12'h000));
        chk("window base", 12'h000, seen_pm);
    endtask : t_window

    task automatic t_decode;
        logic [7:0] ad [24] = '{8'h80, 8'h83, 8'hFF, 8'h84, 8'hBF, 8'hC0,
            8'hC2, 8'hC3, 8'hC4, 8'hC6, 8'hC7, 8'hCC, 8'hCE, 8'hD0, 8'hD1,
            8'hD2, 8'hD4, 8'hD5, 8'hD8, 8'hDB, 8'hC8, 8'hCB, 8'hDC, 8'hE9};
        logic [7:0] d;
        logic [4:0] s;
        for (int i = 0; i < 24; i++)
        begin
            s = (i < 3) ? 5'h10 : (i < 5) ? 5'h08 :
                (i == 7 || i == 10 || i > 19) ? 5'h00 : 5'h04;
            d = (s == 5'h10) ? (ad[i] ^ 8'h44) : (s == 5'h08) ?
                (ad[i] ^ 8'h11) : (s == 5'h04) ? (ad[i] ^ 8'h33) : 8'hFF;
            rd_chk(ad[i], s, d);
        end
        wr_chk(8'h90, 8'hA5, 4'h4);
        chk("write addr", 8'h90, acc_addr_ff);
        chk("write data", 8'hA5, acc_wdata_ff);
        wr_chk(8'hC3, 8'h5A, 4'h0);
        wr_chk(8'hC8, 8'h3C, 4'h2);
    endtask : t_decode

    task automatic t_bank;
        logic [7:0] v [3] = '{8'h10, 8'h02, 8'h01};
        for (int i = 0; i < 3; i++)
        begin
            wr_chk(8'hE8, v[i], 4'h0);
            rd_chk(8'h3F, 5'h02, 8'h3F ^ 8'h22);
            chk("page select", 3'b100 >> i, seen_sel);
            wr_chk(8'h00, v[i], 4'h1);
        end
        wr_chk(8'hE8, 8'h00, 4'h0);
        rd_chk(8'h05, 5'h00, 8'hFF);
        wr_chk(8'hEA, 8'h5A, 4'h0);
        chk("nvm control", 8'h5A, nvm_control_ff);
        rd_chk(8'hEA, 5'h00, 8'h5A);
    endtask : t_bank

    // Reset in mid-run: storage control clears, bank select survives
    task automatic t_reset;
        wr_chk(8'hE8, 8'h10, 4'h0);
        @(negedge ref_clk);
        sys_rst = 1'b1;
        repeat (2) @(negedge ref_clk);
        chk("reset rvalid", 1'b0, cpu_rvalid_ff);
        chk("reset nvm", 8'h00, nvm_control_ff);
        sys_rst = 1'b0;
        rd_chk(8'hEA, 5'h00, 8'h00);
        rd_chk(8'h3F, 5'h02, 8'h3F ^ 8'h22);
    endtask : t_reset

    // Back to back pushes and pops, so the stack order is really exercised
    task automatic t_stack;
        @(negedge ref_clk);
        stack_push = 1'b1;
        for (int i = 1; i <= 7; i++)
        begin
            program_counter = 12'h100 + 12'(i);
            @(negedge ref_clk);
            chk("stack push", 12'h100 + 12'(i), ret_addr_ff);
        end
        // Seven pushes into six levels: the first one must be gone
        stack_push = 1'b0;
        stack_pop = 1'b1;
        for (int j = 0; j < 6; j++)
        begin
            @(negedge ref_clk);
            chk("stack pop", (j < 5) ? 12'h106 - 12'(j) : 12'h102,
                ret_addr_ff);
        end
        stack_pop = 1'b0;
    endtask : t_stack

    task automatic t_ext(input logic prot);
        @(negedge ref_clk);
        readout_protect = prot;
        ext_rd_req = 1'b1;
        ext_addr = 12'h3A7;
        @(negedge ref_clk);
        ext_rd_req = 1'b0;
        ext_addr = 12'hC58;
        chk("ext denied", prot, ext_denied_ff);
        chk("ext pm read", !prot, pm_re_ff);
        @(negedge ref_clk);
        chk("ext ack", !prot, ext_ack_ff);
        if (!prot)
            chk("ext data", pmv(12'h3A7), ext_rdata_ff);
    endtask : t_ext

    initial
    begin
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("reset rvalid", 1'b0, cpu_rvalid_ff);
        chk("reset nvm", 8'h00, nvm_control_ff);
        sys_rst = 1'b0;
        t_window();
        t_decode();
        t_bank();
        t_reset();
        t_stack();
        t_ext(1'b0);
        t_ext(1'b1);
        stop_test();
    end

    // The tests need well under a thousand cycles
    initial
    begin
        #200000;
        fails++;
        stop_test();
    end
endmodule : tb_top
`default_nettype wire
